// file: flash_bus_map.svh
`ifndef FLASH_BUS_MAP_SVH
`define FLASH_BUS_MAP_SVH
`define ADDR_W 17
`define DATA_W 16
`define CLK_PERIOD_NS 10
`define SETUP_NS 20
`define SETUP_CYC ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_NS 60
`define PULSE_CYC ((`PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_NS 80
`define READ_CYC ((`READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROT_US 100
`define PROT_CYC (`PROT_US * 1000 / `CLK_PERIOD_NS)
`define UNPROT_MS 10
`define UNPROT_CYC (`UNPROT_MS * 1000000 / `CLK_PERIOD_NS)
`define TIMER_W 24
`define BIT_A0 0
`define BIT_A1 1
`define BIT_A6 6
`define BIT_A9 9
`define BIT_A12 12
`define BIT_A15 15
`define BLK_LO 12
`define BLK_HI 16
`define UPPER_ZERO 8'h00
`define PROT_YES 8'h01
`endif

// file: flash_bus_pkg.sv
package flash_bus_pkg;
    typedef enum logic [2:0] {
        OP_READ,
        OP_WRITE,
        OP_SIGNATURE,
        OP_PROTECT,
        OP_UNPROTECT,
        OP_VERIFY
    } op_t;
    typedef struct packed {
        logic chipSelN;
        logic outGateN;
        logic writeStrobeN;
        logic byteModeN;
        logic resetUnlockPinN;
    } ctrl_pins_t;
    typedef struct packed {
        logic a9High;
        logic outGateHigh;
        logic chipSelHigh;
        logic resetHigh;
    } hv_pins_t;
    typedef struct packed {
        op_t op;
        logic [16:0] addr;
        logic [15:0] data;
        logic byteMode;
        logic sigBit;
    } req_t;
endpackage : flash_bus_pkg

// file: flash_delay_timer.sv
`timescale 1ns/1ps
`include "flash_bus_map.svh"
module flash_delay_timer
    import flash_bus_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstN,
    input wire logic load,
    input wire logic [`TIMER_W-1:0] loadValue,
    output logic done
);
    logic [`TIMER_W-1:0] count;
    logic [`TIMER_W-1:0] next_count;
    always_comb begin
        next_count = count;
        if (load) begin
            next_count = loadValue;
        end else if (count != '0) begin
            next_count = count - `TIMER_W'(1);
        end
    end
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
    assign done = (count == '0) && !load;
endmodule : flash_delay_timer

// file: flash_bus_host.sv
`timescale 1ns/1ps
`include "flash_bus_map.svh"
module flash_bus_host
    import flash_bus_pkg::*;
#(
    parameter int unsigned PROT_CYCLES = `PROT_CYC,
    parameter int unsigned UNPROT_CYCLES = `UNPROT_CYC
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reqValid,
    input wire req_t req,
    input wire logic tempUnprotect,
    input wire logic [15:0] dataIn,
    output logic reqReady,
    output logic rspValid,
    output logic [15:0] rspData,
    output logic [16:0] addrOut,
    output logic [15:0] dataOut,
    output logic [15:0] dataOe,
    output ctrl_pins_t ctrl,
    output hv_pins_t hv
);
    typedef enum logic [2:0] {
        S_IDLE,
        S_SETUP,
        S_PULSE,
        S_HOLD,
        S_RESP
    } state_t;
    logic rstMeta;
    logic rstN;
    state_t state;
    state_t next_state;
    req_t cur;
    req_t next_cur;
    logic [`TIMER_W-1:0] cnt;
    logic [`TIMER_W-1:0] next_cnt;
    logic timerLoad;
    logic [`TIMER_W-1:0] timerValue;
    logic timerDone;
    logic next_reqReady;
    logic next_rspValid;
    logic [15:0] next_rspData;
    logic [16:0] next_addrOut;
    logic [15:0] next_dataOut;
    logic [15:0] next_dataOe;
    ctrl_pins_t next_ctrl;
    hv_pins_t next_hv;
    logic isRead;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end
    flash_delay_timer u_timer (
        .sys_clk(sys_clk),
        .rstN(rstN),
        .load(timerLoad),
        .loadValue(timerValue),
        .done(timerDone)
    );
    assign isRead = (cur.op == OP_READ) || (cur.op == OP_SIGNATURE) || (cur.op == OP_VERIFY);
    always_comb begin
        next_state = state;
        next_cur = cur;
        next_cnt = cnt;
        timerLoad = 1'b0;
        timerValue = '0;
        next_reqReady = 1'b0;
        next_rspValid = 1'b0;
        next_rspData = rspData;
        next_addrOut = addrOut;
        next_dataOut = dataOut;
        next_dataOe = dataOe;
        next_ctrl = ctrl;
        next_hv = hv;
        next_ctrl.resetUnlockPinN = 1'b1;
        next_hv.resetHigh = tempUnprotect;
        case (state)
            S_IDLE: begin
                next_ctrl.chipSelN = 1'b1;
                next_ctrl.outGateN = 1'b1;
                next_ctrl.writeStrobeN = 1'b1;
                next_hv.a9High = 1'b0;
                next_hv.outGateHigh = 1'b0;
                next_hv.chipSelHigh = 1'b0;
                next_dataOe = '0;
                next_reqReady = 1'b1;
                if (reqValid && reqReady) begin
                    next_reqReady = 1'b0;
                    next_cur = req;
                    next_addrOut = req.addr;
                    next_ctrl.byteModeN = !req.byteMode;
                    next_cnt = `TIMER_W'(`SETUP_CYC);
                    next_state = S_SETUP;
                    case (req.op)
                        OP_SIGNATURE: begin
                            next_hv.a9High = 1'b1;
                            next_addrOut[`BIT_A1] = 1'b0;
                            next_addrOut[`BIT_A0] = req.sigBit;
                        end
                        OP_VERIFY: begin
                            next_hv.a9High = 1'b1;
                            next_addrOut[`BIT_A0] = 1'b0;
                            next_addrOut[`BIT_A1] = 1'b1;
                            next_addrOut[`BIT_A6] = 1'b0;
                        end
                        OP_PROTECT: begin
                            next_hv.a9High = 1'b1;
                            next_hv.outGateHigh = 1'b1;
                            next_ctrl.chipSelN = 1'b0;
                        end
                        OP_UNPROTECT: begin
                            next_hv.a9High = 1'b1;
                            next_hv.outGateHigh = 1'b1;
                            next_hv.chipSelHigh = 1'b1;
                            next_addrOut[`BIT_A12] = 1'b1;
                            next_addrOut[`BIT_A15] = 1'b1;
                        end
                        OP_WRITE: begin
                            next_ctrl.chipSelN = 1'b0;
                            next_dataOut = req.data;
                            next_dataOe = req.byteMode ? 16'h00FF : 16'hFFFF;
                            if (req.byteMode) begin
                                next_dataOut[15] = req.sigBit;
                                next_dataOe[15] = 1'b1;
                            end
                        end
                        default: begin
                            next_ctrl.chipSelN = 1'b0;
                            if (req.byteMode) begin
                                next_dataOut[15] = req.sigBit;
                                next_dataOe[15] = 1'b1;
                            end
                        end
                    endcase
                end
            end
            S_SETUP: begin
                if (cnt > `TIMER_W'(1)) begin
                    next_cnt = cnt - `TIMER_W'(1);
                end else begin
                    next_state = S_PULSE;
                    if (isRead) begin
                        next_ctrl.chipSelN = 1'b0;
                        next_ctrl.outGateN = 1'b0;
                        next_cnt = `TIMER_W'(`READ_CYC);
                    end else if (cur.op == OP_WRITE) begin
                        next_ctrl.writeStrobeN = 1'b0;
                        next_cnt = `TIMER_W'(`PULSE_CYC);
                    end else begin
                        next_ctrl.writeStrobeN = 1'b0;
                        timerLoad = 1'b1;
                        timerValue = (cur.op == OP_PROTECT) ? `TIMER_W'(PROT_CYCLES) : `TIMER_W'(UNPROT_CYCLES);
                    end
                end
            end
            S_PULSE: begin
                if (cur.op == OP_PROTECT || cur.op == OP_UNPROTECT) begin
                    if (timerDone) begin
                        next_ctrl.writeStrobeN = 1'b1;
                        next_cnt = `TIMER_W'(`SETUP_CYC);
                        next_state = S_HOLD;
                    end
                end else if (cnt > `TIMER_W'(1)) begin
                    next_cnt = cnt - `TIMER_W'(1);
                end else begin
                    if (isRead) begin
                        next_rspData = dataIn;
                        if (cur.byteMode || cur.op != OP_READ) begin
                            next_rspData[15:8] = `UPPER_ZERO;
                        end
                        next_ctrl.outGateN = 1'b1;
                        next_ctrl.chipSelN = 1'b1;
                    end else begin
                        next_ctrl.writeStrobeN = 1'b1;
                    end
                    next_cnt = `TIMER_W'(`SETUP_CYC);
                    next_state = S_HOLD;
                end
            end
            S_HOLD: begin
                if (cnt > `TIMER_W'(1)) begin
                    next_cnt = cnt - `TIMER_W'(1);
                end else begin
                    next_ctrl.chipSelN = 1'b1;
                    next_dataOe = '0;
                    next_hv.a9High = 1'b0;
                    next_hv.outGateHigh = 1'b0;
                    next_hv.chipSelHigh = 1'b0;
                    next_state = S_RESP;
                end
            end
            S_RESP: begin
                next_rspValid = 1'b1;
                next_state = S_IDLE;
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            state <= S_IDLE;
            cur <= '0;
            cnt <= '0;
            reqReady <= 1'b0;
            rspValid <= 1'b0;
            rspData <= '0;
            addrOut <= '0;
            dataOut <= '0;
            dataOe <= '0;
            ctrl <= '1;
            hv <= '0;
        end else begin
            state <= next_state;
            cur <= next_cur;
            cnt <= next_cnt;
            reqReady <= next_reqReady;
            rspValid <= next_rspValid;
            rspData <= next_rspData;
            addrOut <= next_addrOut;
            dataOut <= next_dataOut;
            dataOe <= next_dataOe;
            ctrl <= next_ctrl;
            hv <= next_hv;
        end
    end
endmodule : flash_bus_host

// file: flash_bus_host_asserts.sv
`timescale 1ns/1ps
module flash_bus_host_asserts
    import flash_bus_pkg::*;
#(
    parameter int unsigned PROT_CYCLES = 10000,
    parameter int unsigned UNPROT_CYCLES = 1000000
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reqReady,
    input wire logic [16:0] addrOut,
    input wire logic [15:0] dataOut,
    input wire logic [15:0] dataOe,
    input wire ctrl_pins_t ctrl,
    input wire hv_pins_t hv
);
    logic [31:0] lowCnt;
    logic [31:0] next_lowCnt;
    always_comb next_lowCnt = ctrl.writeStrobeN ? 32'h0 : lowCnt + 32'h1;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) lowCnt <= 32'h0;
        else lowCnt <= next_lowCnt;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence gateOpen;
        !ctrl.chipSelN && !ctrl.outGateN;
    endsequence
    sequence busIdle;
        ctrl.chipSelN && ctrl.outGateN && ctrl.writeStrobeN && !hv.a9High && !hv.outGateHigh && !hv.chipSelHigh;
    endsequence
    read_gate_a: assert property (!ctrl.outGateN |-> !ctrl.chipSelN && ctrl.writeStrobeN) else $error("gate bad");
    write_ctrl_a: assert property (!ctrl.writeStrobeN && !hv.a9High |-> !ctrl.chipSelN && ctrl.outGateN)
        else $error("write pins bad");
    addr_hold_a: assert property (!ctrl.writeStrobeN |-> $stable(addrOut)) else $error("address moved");
    data_hold_a: assert property ($rose(ctrl.writeStrobeN) && !hv.a9High |-> $stable(dataOut) ##1 dataOe[7:0] == 8'hFF)
        else $error("data released early");
    idle_bus_a: assert property (reqReady |-> busIdle) else $error("bus not idle");
    no_drive_a: assert property (gateOpen |-> dataOe[14:0] == 15'h0) else $error("host drives in read");
    prot_setup_a: assert property ($fell(ctrl.writeStrobeN) && hv.a9High && !hv.chipSelHigh
        |-> hv.outGateHigh && !ctrl.chipSelN) else $error("protect setup bad");
    prot_len_a: assert property ($rose(ctrl.writeStrobeN) && hv.a9High && !hv.chipSelHigh
        |-> lowCnt >= PROT_CYCLES && lowCnt <= PROT_CYCLES + 1) else $error("protect pulse length");
    unprot_setup_a: assert property ($fell(ctrl.writeStrobeN) && hv.chipSelHigh
        |-> hv.a9High && hv.outGateHigh && addrOut[12] && addrOut[15] && ctrl.chipSelN) else $error("unprotect setup");
    unprot_len_a: assert property ($rose(ctrl.writeStrobeN) && hv.chipSelHigh
        |-> lowCnt >= UNPROT_CYCLES && lowCnt <= UNPROT_CYCLES + 1) else $error("unprotect pulse length");
    pin_high_a: assert property (ctrl.resetUnlockPinN) else $error("reset pin low");
endmodule : flash_bus_host_asserts
bind flash_bus_host flash_bus_host_asserts #(.PROT_CYCLES(PROT_CYCLES), .UNPROT_CYCLES(UNPROT_CYCLES)) chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .reqReady(reqReady), .addrOut(addrOut), .dataOut(dataOut),
    .dataOe(dataOe), .ctrl(ctrl), .hv(hv));

// file: flash_model.sv
`timescale 1ns/1ps
module flash_model
    import flash_bus_pkg::*;
#(
    parameter logic [7:0] MAKER_ID = 8'h5A,
    parameter logic [7:0] PART_ID = 8'h6B
)
(
    input wire logic sys_clk,
    input wire logic [16:0] addrOut,
    input wire logic [15:0] dataOut,
    input wire logic [15:0] dataOe,
    input wire ctrl_pins_t ctrl,
    input wire hv_pins_t hv,
    output logic [15:0] dataIn
);
    // identity values are arbitrary
    logic [15:0] mem [16] = '{default: 16'h0000};
    logic [31:0] prot = 32'h0;
    logic [15:0] q;
    logic [15:0] qOe;
    logic [3:0] wAddr;
    logic flip = 1'h0;
    wire logic byteMode = !ctrl.byteModeN;
    wire logic wrAct = !ctrl.chipSelN && !ctrl.writeStrobeN && ctrl.outGateN && !hv.a9High;
    wire logic [3:0] idx = byteMode ? {addrOut[2:0], dataOut[15]} : addrOut[3:0];
    always @(posedge wrAct) wAddr = idx;
    always @(negedge wrAct) begin
        if (hv.resetHigh || !prot[addrOut[16:12]]) mem[wAddr] = byteMode ? {8'h00, dataOut[7:0]} : dataOut;
    end
    always @(posedge ctrl.writeStrobeN) begin
        if (hv.a9High && hv.outGateHigh) prot = hv.chipSelHigh ? 32'h0 : prot | (32'h1 << addrOut[16:12]);
    end
    always_comb begin
        q = mem[idx];
        if (hv.a9High) q = addrOut[1] ? {15'h0, prot[addrOut[16:12]]} : {8'h00, addrOut[0] ? PART_ID : MAKER_ID};
        qOe = 16'h0000;
        if (ctrl.resetUnlockPinN && !ctrl.chipSelN && !ctrl.outGateN) qOe = byteMode ? 16'h00FF : 16'hFFFF;
    end
    always @(posedge sys_clk) flip <= !flip;
    always_comb begin
        for (int i = 0; i < 16; i++) dataIn[i] = qOe[i] ? q[i] : dataOe[i] ? dataOut[i] : flip ^ i[0];
    end
endmodule : flash_model

// file: flash_bus_operation_decode_bench.sv
`timescale 1ns/1ps
module flash_bus_operation_decode_bench;
    import flash_bus_pkg::*;
    localparam logic [7:0] MAKER = 8'h5A;
    localparam logic [7:0] PART = 8'h6B;
    logic sys_clk = 1'h0;
    logic rst_n = 1'h0;
    logic reqValid = 1'h0;
    logic tempUnprotect = 1'h0;
    req_t req = '0;
    logic reqReady, rspValid;
    logic [15:0] rspData, dataOut, dataOe, dataIn;
    logic [16:0] addrOut;
    ctrl_pins_t ctrl;
    hv_pins_t hv;
    logic [15:0] shadow [16] = '{default: 16'h0000};
    logic [31:0] prot = 32'h0;
    int failures = 0;
    int testsRun = 0;
    flash_bus_host #(.PROT_CYCLES(20), .UNPROT_CYCLES(30)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .reqValid(reqValid),
        .req(req), .tempUnprotect(tempUnprotect), .dataIn(dataIn), .reqReady(reqReady), .rspValid(rspValid),
        .rspData(rspData), .addrOut(addrOut), .dataOut(dataOut), .dataOe(dataOe), .ctrl(ctrl), .hv(hv));
    flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) dev (.sys_clk(sys_clk), .addrOut(addrOut), .dataOut(dataOut),
        .dataOe(dataOe), .ctrl(ctrl), .hv(hv), .dataIn(dataIn));
    initial forever #5 sys_clk = ~sys_clk;
    task automatic complete_run;
        if (failures == 0 && testsRun > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic op(input op_t o, input logic [16:0] a, input logic [15:0] d, input logic bm, input logic sb);
        int n;
        n = 0;
        req <= '{o, a, d, bm, sb};
        reqValid <= 1'h1;
        do begin
            @(negedge sys_clk);
            n++;
        end while (reqReady !== 1'h1 && n < 50);
        @(posedge sys_clk);
        reqValid <= 1'h0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (rspValid !== 1'h1 && n < 200);
        @(posedge sys_clk);
        chk(16'(n < 200), 16'h1);
    endtask : op
    function automatic logic [3:0] ix(input logic [16:0] a, input logic bm, input logic sb);
        return bm ? {a[2:0], sb} : a[3:0];
    endfunction : ix
    task automatic wr(input logic [16:0] a, input logic [15:0] d, input logic bm, input logic sb);
        op(OP_WRITE, a, d, bm, sb);
        if (!prot[a[16:12]] || tempUnprotect) shadow[ix(a, bm, sb)] = bm ? {8'h00, d[7:0]} : d;
    endtask : wr
    task automatic rd(input logic [16:0] a, input logic bm, input logic sb);
        op(OP_READ, a, 16'h0, bm, sb);
        chk(rspData, bm ? {8'h00, shadow[ix(a, bm, sb)][7:0]} : shadow[ix(a, bm, sb)]);
    endtask : rd
    task automatic verify(input logic [16:0] a, input logic [15:0] exp);
        op(OP_VERIFY, a, 16'h0, 1'h0, 1'h0);
        chk(rspData, exp);
    endtask : verify
    initial begin
        logic [16:0] a;
        logic [15:0] d;
        void'($urandom(13));
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'h1;
        repeat (4) @(posedge sys_clk);
        chk({13'h0, ctrl.chipSelN, ctrl.outGateN, ctrl.writeStrobeN}, 16'h7);
        for (int i = 0; i < 24; i++) begin
            a = 17'($urandom);
            d = 16'($urandom);
            wr(a, d, i[0], d[15]);
            rd(a, i[0], d[15]);
            if (i % 3 == 0) rd(a ^ 17'h1, i[0], ~d[15]);
        end
        for (int s = 0; s < 4; s++) begin
            op(OP_SIGNATURE, {16'h0, s[0]}, 16'h0, s[1], s[0]);
            chk(rspData, {8'h00, s[0] ? PART : MAKER});
        end
        a = {5'h13, 12'h005};
        wr(a, 16'h1234, 1'h0, 1'h0);
        op(OP_PROTECT, a, 16'h0, 1'h0, 1'h0);
        prot[5'h13] = 1'h1;
        verify(a, 16'h0001);
        verify(17'h08005, 16'h0000);
        wr(a, 16'hBEEF, 1'h0, 1'h0);
        rd(a, 1'h0, 1'h0);
        tempUnprotect <= 1'h1;
        repeat (4) @(posedge sys_clk);
        wr(a, 16'hC0DE, 1'h0, 1'h0);
        rd(a, 1'h0, 1'h0);
        tempUnprotect <= 1'h0;
        repeat (4) @(posedge sys_clk);
        op(OP_UNPROTECT, a, 16'h0, 1'h0, 1'h0);
        prot = 32'h0;
        verify(a, 16'h0000);
        wr(a, 16'h5A5A, 1'h0, 1'h0);
        rd(a, 1'h0, 1'h0);
        rst_n <= 1'h0;
        repeat (3) @(posedge sys_clk);
        chk({14'h0, ctrl.chipSelN, reqReady}, 16'h2);
        rst_n <= 1'h1;
        repeat (5) @(posedge sys_clk);
        rd(a, 1'h0, 1'h0);
        complete_run();
    end
    initial begin
        #200us;
        failures++;
        complete_run();
    end
endmodule : flash_bus_operation_decode_bench
